// >>> design/burst_order_gen.sv
`timescale 1ns/1ns
module burst_order_gen
(
    burst_order_if.gen bus
);
    logic [ddr_burst_pkg::COL_W-1:0] cols [2];

    // Each clock carries two elements: index k and k+1.
    for (genvar e = 0; e < 2; e++)
    begin : g_elem
        logic [3:0]                      k;
        logic [3:0]                      off;
        logic [ddr_burst_pkg::COL_W-1:0] mask;
        always_comb
        begin
            k    = bus.index + 4'(e);
            off  = bus.interleave ? (bus.start_col[3:0] ^ k) : (bus.start_col[3:0] + k);
            mask = ddr_burst_pkg::block_mask(bus.lg);
            cols[e] = (bus.start_col & ~mask)
                    | ({{(ddr_burst_pkg::COL_W-4){1'b0}}, off} & mask);
        end
    end

    assign bus.col_rise = cols[0];
    assign bus.col_fall = cols[1];
endmodule

// >>> design/burst_order_if.sv
`timescale 1ns/1ns
interface burst_order_if;
    logic [ddr_burst_pkg::COL_W-1:0] start_col;
    logic [2:0]                      lg;
    logic                            interleave;
    logic [3:0]                      index;
    logic [ddr_burst_pkg::COL_W-1:0] col_rise;
    logic [ddr_burst_pkg::COL_W-1:0] col_fall;

    modport seq (output start_col, lg, interleave, index, input col_rise, col_fall);
    modport gen (input start_col, lg, interleave, index, output col_rise, col_fall);
endinterface

// >>> design/ddr_burst_order_latency.sv
`timescale 1ns/1ns
module ddr_burst_order_latency
(
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            cmd_read,
    input  wire logic                            cmd_write,
    input  wire logic                            cmd_mode_load,
    input  wire logic                            bank_select_low,
    input  wire logic                            bank_select_high,
    input  wire logic [ddr_burst_pkg::ADDR_W-1:0] cmd_addr,
    output logic                                 acc_valid,
    output logic                                 acc_write,
    output logic      [ddr_burst_pkg::COL_W-1:0] acc_col_rise,
    output logic      [ddr_burst_pkg::COL_W-1:0] acc_col_fall,
    output logic                                 rd_valid,
    output logic      [ddr_burst_pkg::COL_W-1:0] rd_col_rise,
    output logic      [ddr_burst_pkg::COL_W-1:0] rd_col_fall,
    output logic      [2:0]                      burst_len_setting,
    output logic                                 burst_interleaved,
    output logic      [2:0]                      read_latency_setting,
    output logic                                 mode_busy,
    output logic                                 mode_reject,
    output logic                                 cmd_refused
);
    localparam int CW = ddr_burst_pkg::COL_W;

    burst_order_if ord ();

    ddr_burst_pkg::seq_state_t state;
    ddr_burst_pkg::seq_state_t next_state;
    logic          burst_read;
    logic          next_burst_read;
    logic [CW-1:0] start_col;
    logic [CW-1:0] next_start_col;
    logic [3:0]    index;
    logic [3:0]    next_index;
    logic [3:0]    wait_cnt;
    logic [3:0]    next_wait_cnt;
    logic [2:0]    next_burst_len_setting;
    logic          next_burst_interleaved;
    logic [2:0]    next_read_latency_setting;
    logic          next_mode_reject;
    logic          next_cmd_refused;
    logic          next_acc_valid;
    logic          next_acc_write;
    logic [CW-1:0] next_acc_col_rise;
    logic [CW-1:0] next_acc_col_fall;

    logic       std_select;
    logic       mode_fields_ok;
    logic       mode_take;
    logic       rw_cmd;
    logic       rw_go;
    logic [2:0] lg;
    logic [4:0] burst_len;
    logic       last_pair;
    logic [2:0] new_len;
    logic [2:0] new_lat;

    // The sequencer works from the stored settings and the command's column only.
    assign lg              = ddr_burst_pkg::len_log(burst_len_setting);
    assign burst_len       = 5'(5'h01 << lg);
    assign last_pair       = ({1'b0, index} + 5'h02) >= burst_len;
    assign ord.start_col   = start_col;
    assign ord.lg          = lg;
    assign ord.interleave  = burst_interleaved;
    assign ord.index       = index;

    burst_order_gen u_gen
    (
        .bus (ord)
    );

    read_latency_delay u_delay
    (
        .clk       (clk),
        .rstn      (rstn),
        .lat3      (read_latency_setting == ddr_burst_pkg::LAT_CODE_3),
        .in_valid  (state == ddr_burst_pkg::ST_BURST && burst_read),
        .in_rise   (ord.col_rise),
        .in_fall   (ord.col_fall),
        .out_valid (rd_valid),
        .out_rise  (rd_col_rise),
        .out_fall  (rd_col_fall)
    );

    always_comb
    begin
        new_len = cmd_addr[ddr_burst_pkg::MR_LEN_LSB +: 3];
        new_lat = cmd_addr[ddr_burst_pkg::MR_LAT_LSB +: 3];
        std_select = cmd_mode_load && !bank_select_low && !bank_select_high;
        mode_fields_ok = (new_len >= ddr_burst_pkg::LEN_CODE_2)
                      && (new_len <= ddr_burst_pkg::LEN_CODE_16)
                      && ((new_lat == ddr_burst_pkg::LAT_CODE_2)
                       || (new_lat == ddr_burst_pkg::LAT_CODE_3))
                      && (cmd_addr[ddr_burst_pkg::ADDR_W-1:ddr_burst_pkg::MR_OPMODE_LSB] == '0);
        mode_take = std_select && mode_fields_ok
                 && (state == ddr_burst_pkg::ST_IDLE) && (wait_cnt == 4'h0);
        rw_cmd = !cmd_mode_load && (cmd_read || cmd_write);
        rw_go  = rw_cmd && (wait_cnt == 4'h0);
    end

    // Settings and the mode-load wait.
    always_comb
    begin
        next_burst_len_setting    = burst_len_setting;
        next_burst_interleaved    = burst_interleaved;
        next_read_latency_setting = read_latency_setting;
        next_wait_cnt             = (wait_cnt != 4'h0) ? wait_cnt - 4'h1 : 4'h0;
        next_mode_reject          = std_select && !mode_take;
        next_cmd_refused          = rw_cmd && !rw_go;
        if (mode_take)
        begin
            next_burst_len_setting    = new_len;
            next_burst_interleaved    = cmd_addr[ddr_burst_pkg::MR_TYPE_BIT];
            next_read_latency_setting = new_lat;
            next_wait_cnt             = ddr_burst_pkg::MODE_LOAD_WAIT_CYC;
        end
    end

    // Burst sequencer: a new READ or WRITE cuts short any burst in flight.
    always_comb
    begin
        next_state      = state;
        next_burst_read = burst_read;
        next_start_col  = start_col;
        next_index      = index;
        if (state == ddr_burst_pkg::ST_BURST)
        begin
            next_index = index + 4'h2;
            if (last_pair)
            begin
                next_state = ddr_burst_pkg::ST_IDLE;
                next_index = 4'h0;
            end
        end
        if (rw_go)
        begin
            next_state      = ddr_burst_pkg::ST_BURST;
            next_burst_read = cmd_read;
            next_start_col  = cmd_addr[CW-1:0];
            next_index      = 4'h0;
        end
        next_acc_valid    = (state == ddr_burst_pkg::ST_BURST);
        next_acc_write    = (state == ddr_burst_pkg::ST_BURST) && !burst_read;
        next_acc_col_rise = ord.col_rise;
        next_acc_col_fall = ord.col_fall;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state                <= ddr_burst_pkg::ST_IDLE;
            burst_read           <= 1'b0;
            start_col            <= '0;
            index                <= 4'h0;
            wait_cnt             <= 4'h0;
            burst_len_setting    <= ddr_burst_pkg::RST_LEN_CODE;
            burst_interleaved    <= ddr_burst_pkg::RST_INTERLEAVE;
            read_latency_setting <= ddr_burst_pkg::RST_LAT_CODE;
            mode_busy            <= 1'b0;
            mode_reject          <= 1'b0;
            cmd_refused          <= 1'b0;
            acc_valid            <= 1'b0;
            acc_write            <= 1'b0;
            acc_col_rise         <= '0;
            acc_col_fall         <= '0;
        end
        else
        begin
            state                <= next_state;
            burst_read           <= next_burst_read;
            start_col            <= next_start_col;
            index                <= next_index;
            wait_cnt             <= next_wait_cnt;
            burst_len_setting    <= next_burst_len_setting;
            burst_interleaved    <= next_burst_interleaved;
            read_latency_setting <= next_read_latency_setting;
            mode_busy            <= (next_wait_cnt != 4'h0);
            mode_reject          <= next_mode_reject;
            cmd_refused          <= next_cmd_refused;
            acc_valid            <= next_acc_valid;
            acc_write            <= next_acc_write;
            acc_col_rise         <= next_acc_col_rise;
            acc_col_fall         <= next_acc_col_fall;
        end
    end

    // Helper for the checks: pairs issued since the burst began.
    logic [4:0]    pair_cnt;
    logic [CW-1:0] mask_now;
    assign mask_now = ddr_burst_pkg::block_mask(lg);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pair_cnt <= 5'h00;
        else if (rw_go)
            pair_cnt <= 5'h00;
        else if (state == ddr_burst_pkg::ST_BURST)
            pair_cnt <= pair_cnt + 5'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    burst_count_a: assert property ((state == ddr_burst_pkg::ST_BURST) |->
        ({pair_cnt, 1'b0} < {1'b0, burst_len}))
        else $error("Burst issued more columns than its length.");

    block_fixed_a: assert property (acc_valid |->
        (((acc_col_rise ^ acc_col_fall) & ~mask_now) == '0))
        else $error("Burst left its column block.");

    block_start_a: assert property (rw_go |=> ##1 (acc_valid &&
        ((acc_col_rise & ~mask_now) == ($past(cmd_addr[CW-1:0], 2) & ~mask_now))))
        else $error("Block bits differ from the command column.");

    first_elem_a: assert property (rw_go |-> ##2 (acc_col_rise == $past(cmd_addr[CW-1:0], 2)))
        else $error("First element is not the starting column.");

    seq_order_a: assert property ((acc_valid && !burst_interleaved) |->
        ((acc_col_fall & mask_now) == ((acc_col_rise + CW'(1)) & mask_now)))
        else $error("Sequential step is not plus one.");

    ilv_order_a: assert property ((acc_valid && burst_interleaved) |->
        (acc_col_fall == (acc_col_rise ^ CW'(1))))
        else $error("Interleaved pair is not offset XOR one.");

    mode_hold_a: assert property (!mode_take |=>
        $stable(burst_interleaved) && $stable(burst_len_setting))
        else $error("Mode settings changed without a mode load.");

    latency_legal_a: assert property ((read_latency_setting == ddr_burst_pkg::LAT_CODE_2)
        || (read_latency_setting == ddr_burst_pkg::LAT_CODE_3))
        else $error("Read latency setting is neither two nor three.");

    read_lat2_a: assert property ((rw_go && cmd_read &&
        read_latency_setting == ddr_burst_pkg::LAT_CODE_2) |-> ##2 (rd_valid && acc_valid))
        else $error("Latency two read data not after edge n+1.");

    read_lat3_a: assert property ((rw_go && cmd_read && !rd_valid && !acc_valid &&
        state == ddr_burst_pkg::ST_IDLE &&
        read_latency_setting == ddr_burst_pkg::LAT_CODE_3) |-> ##2 !rd_valid ##1 rd_valid)
        else $error("Latency three read data not after edge n+2.");

    mode_bank_a: assert property ((cmd_mode_load && (bank_select_low || bank_select_high))
        |=> $stable(read_latency_setting) && !mode_reject)
        else $error("Mode load to another register touched the settings.");

    // The load wait covers two cycles; commands inside it are refused.
    mode_busy_a: assert property (mode_take |=> mode_busy ##1 mode_busy ##1 !mode_busy)
        else $error("Mode busy did not span the load wait.");

    rw_refuse_a: assert property ((rw_cmd && (wait_cnt != 4'h0)) |=>
        (cmd_refused && $stable(start_col)))
        else $error("Command during the load wait was not refused.");

    mode_running_a: assert property ((std_select &&
        (state == ddr_burst_pkg::ST_BURST)) |=> mode_reject)
        else $error("Mode load during a burst was not refused.");

    mode_wins_a: assert property ((cmd_mode_load &&
        (state == ddr_burst_pkg::ST_IDLE)) |=> (state == ddr_burst_pkg::ST_IDLE))
        else $error("Command given with a mode load started a burst.");

    reserved_code_a: assert property ((std_select && !mode_fields_ok) |=> (mode_reject &&
        $stable(burst_len_setting) && $stable(read_latency_setting)))
        else $error("Reserved mode code was not refused.");

    block_hold_a: assert property (acc_valid |->
        ((acc_col_rise & ~mask_now) == ($past(start_col) & ~mask_now)))
        else $error("Block bits moved during the burst.");

    write_flag_a: assert property ((rw_go && cmd_write) |-> ##2 (acc_valid && acc_write))
        else $error("Write burst not marked as a write.");

    // Read columns repeat the access columns, one stage later at latency three.
    read_pair_two_a: assert property ((rd_valid &&
        ($past(read_latency_setting) == ddr_burst_pkg::LAT_CODE_2)) |->
        ((rd_col_rise == acc_col_rise) && (rd_col_fall == acc_col_fall)))
        else $error("Latency two read pair differs from the access pair.");

    read_pair_three_a: assert property ((rd_valid &&
        ($past(read_latency_setting) == ddr_burst_pkg::LAT_CODE_3)) |->
        ((rd_col_rise == $past(acc_col_rise)) && (rd_col_fall == $past(acc_col_fall))))
        else $error("Latency three read pair differs from the access pair.");

endmodule

// >>> design/ddr_burst_pkg.sv
package ddr_burst_pkg;

    localparam int ADDR_W = 13;
    localparam int COL_W  = 10;

    // Field layout of the standard mode register as carried on the address pins.
    localparam int MR_LEN_LSB    = 0;
    localparam int MR_TYPE_BIT   = 3;
    localparam int MR_LAT_LSB    = 4;
    localparam int MR_OPMODE_LSB = 7;

    localparam logic [2:0] LEN_CODE_2  = 3'h1;
    localparam logic [2:0] LEN_CODE_4  = 3'h2;
    localparam logic [2:0] LEN_CODE_8  = 3'h3;
    localparam logic [2:0] LEN_CODE_16 = 3'h4;
    localparam logic [2:0] LAT_CODE_2  = 3'h2;
    localparam logic [2:0] LAT_CODE_3  = 3'h3;

    localparam logic [2:0] RST_LEN_CODE   = LEN_CODE_4;
    localparam logic       RST_INTERLEAVE = 1'b0;
    localparam logic [2:0] RST_LAT_CODE   = LAT_CODE_3;

    localparam int CLK_PERIOD_NS      = 100;
    localparam int MODE_LOAD_WAIT_NS  = 200;
    localparam int MODE_LOAD_WAIT_RAW = (MODE_LOAD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] MODE_LOAD_WAIT_CYC =
        4'((MODE_LOAD_WAIT_RAW < 1) ? 1 : MODE_LOAD_WAIT_RAW);

    typedef enum logic [0:0] {ST_IDLE, ST_BURST} seq_state_t;

    // Number of in-block offset bits for a burst length code: 1 to 4.
    function automatic logic [2:0] len_log(input logic [2:0] code);
        case (code)
            LEN_CODE_2: len_log = 3'h1;
            LEN_CODE_4: len_log = 3'h2;
            LEN_CODE_8: len_log = 3'h3;
            default:    len_log = 3'h4;
        endcase
    endfunction

    // Mask of the column bits that move within a burst.
    function automatic logic [COL_W-1:0] block_mask(input logic [2:0] lg);
        block_mask = COL_W'((11'h001 << lg) - 11'h001);
    endfunction

endpackage

// >>> design/read_latency_delay.sv
`timescale 1ns/1ns
module read_latency_delay
(
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            lat3,
    input  wire logic                            in_valid,
    input  wire logic [ddr_burst_pkg::COL_W-1:0] in_rise,
    input  wire logic [ddr_burst_pkg::COL_W-1:0] in_fall,
    output logic                                 out_valid,
    output logic      [ddr_burst_pkg::COL_W-1:0] out_rise,
    output logic      [ddr_burst_pkg::COL_W-1:0] out_fall
);
    logic                            mid_valid;
    logic [ddr_burst_pkg::COL_W-1:0] mid_rise;
    logic [ddr_burst_pkg::COL_W-1:0] mid_fall;
    logic                            next_out_valid;
    logic [ddr_burst_pkg::COL_W-1:0] next_out_rise;
    logic [ddr_burst_pkg::COL_W-1:0] next_out_fall;

    // Latency two loads the output stage directly; latency three passes the middle stage.
    always_comb
    begin
        next_out_valid = lat3 ? mid_valid : in_valid;
        next_out_rise  = lat3 ? mid_rise  : in_rise;
        next_out_fall  = lat3 ? mid_fall  : in_fall;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mid_valid <= 1'b0;
            mid_rise  <= '0;
            mid_fall  <= '0;
            out_valid <= 1'b0;
            out_rise  <= '0;
            out_fall  <= '0;
        end
        else
        begin
            mid_valid <= in_valid;
            mid_rise  <= in_rise;
            mid_fall  <= in_fall;
            out_valid <= next_out_valid;
            out_rise  <= next_out_rise;
            out_fall  <= next_out_fall;
        end
    end
endmodule

// >>> dv/ddr_burst_order_latency_tb_top.sv
`timescale 1ns/1ns
module ddr_burst_order_latency_tb_top;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cmd_read, cmd_write, cmd_mode_load, bank_select_low, bank_select_high;
    logic [12:0] cmd_addr;
    logic       acc_valid, acc_write, rd_valid, burst_interleaved, mode_busy, mode_reject;
    logic       cmd_refused;
    logic [9:0] acc_col_rise, acc_col_fall, rd_col_rise, rd_col_fall;
    logic [2:0] burst_len_setting, read_latency_setting;
    int         miscompares = 0;
    int         comparisons = 0;

    always #50 clk = ~clk;

    mem_ctrl_model i_mem_ctrl_model (.clk(clk), .cmd_read(cmd_read), .cmd_write(cmd_write),
        .cmd_mode_load(cmd_mode_load), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .cmd_addr(cmd_addr));

    ddr_burst_order_latency i_ddr_burst_order_latency (.clk(clk), .rstn(rstn),
        .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_mode_load(cmd_mode_load),
        .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
        .cmd_addr(cmd_addr), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_col_rise(acc_col_rise), .acc_col_fall(acc_col_fall), .rd_valid(rd_valid),
        .rd_col_rise(rd_col_rise), .rd_col_fall(rd_col_fall),
        .burst_len_setting(burst_len_setting), .burst_interleaved(burst_interleaved),
        .read_latency_setting(read_latency_setting), .mode_busy(mode_busy),
        .mode_reject(mode_reject), .cmd_refused(cmd_refused));

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic check_settings(input logic [2:0] len, input logic il, input logic [2:0] lat);
        check("burst_len_setting", 16'(burst_len_setting), 16'(len));
        check("burst_interleaved", 16'(burst_interleaved), 16'(il));
        check("read_latency_setting", 16'(read_latency_setting), 16'(lat));
    endtask

    // A hung load wait counts as a miscompare and closes the run.
    task automatic wait_idle();
        for (int i = 0; i < 10 && mode_busy !== 1'b0; i++) @(negedge clk);
        if (mode_busy !== 1'b0)
        begin
            miscompares++;
            $display("[FAIL] mode_busy expected 0 seen %b", mode_busy);
            end_sim();
        end
    endtask

    // Column of element k: upper bits fixed, in-block offset advanced or flipped.
    function automatic logic [9:0] exp_col(input logic [9:0] st, input int lg, input logic il,
                                           input int k);
        logic [9:0] m;
        m = 10'((1 << lg) - 1);
        exp_col = (st & ~m) | ((il ? (st ^ 10'(k)) : (st + 10'(k))) & m);
    endfunction

    task automatic t_burst(input logic wr, input logic [9:0] st, input int lg, input logic il,
                           input int lat);
        int n;
        int d;
        logic rdv;
        n = 1 << (lg - 1);
        d = lat - 1;
        i_mem_ctrl_model.send(!wr, wr, 1'b0, 2'h0, {3'h0, st});
        for (int c = 1; c <= n + 3; c++)
        begin
            @(negedge clk);
            rdv = !wr && c >= d && c < d + n;
            check("acc_valid", 16'(acc_valid), 16'(c <= n));
            if (c <= n)
            begin
                check("acc_write", 16'(acc_write), 16'(wr));
                check("acc_col_rise", 16'(acc_col_rise), 16'(exp_col(st, lg, il, 2*c-2)));
                check("acc_col_fall", 16'(acc_col_fall), 16'(exp_col(st, lg, il, 2*c-1)));
            end
            check("rd_valid", 16'(rd_valid), 16'(rdv));
            if (rdv)
            begin
                check("rd_col_rise", 16'(rd_col_rise), 16'(exp_col(st, lg, il, 2*(c-d))));
                check("rd_col_fall", 16'(rd_col_fall), 16'(exp_col(st, lg, il, 2*(c-d)+1)));
            end
        end
    endtask

    task automatic t_reset();
        check_settings(3'h2, 1'b0, 3'h3);
        check("mode_busy", 16'(mode_busy), 16'h0000);
        check("acc_valid", 16'(acc_valid), 16'h0000);
        $display("test reset done");
    endtask

    // Every length with both orders; latency alternates so both values are used.
    task automatic t_modes();
        logic [2:0] lat;
        for (int lg = 1; lg <= 4; lg++)
        begin
            for (int il = 0; il < 2; il++)
            begin
                lat = ((lg + il) % 2 != 0) ? 3'h3 : 3'h2;
                i_mem_ctrl_model.load_mode({6'h00, lat, 1'(il), 3'(lg)});
                check_settings(3'(lg), 1'(il), lat);
                t_burst(1'b0, 10'h123, lg, 1'(il), int'(lat));
                t_burst(1'b0, 10'h3FE, lg, 1'(il), int'(lat));
                t_burst(1'b1, 10'h0B5, lg, 1'(il), int'(lat));
            end
        end
        $display("test modes done");
    endtask

    // Pulses are checked in the cycle after the command edge, while they stand.
    task automatic t_busy();
        i_mem_ctrl_model.send(1'b0, 1'b0, 1'b1, 2'h0, 13'h003B);
        check_settings(3'h3, 1'b1, 3'h3);
        check("mode_busy", 16'(mode_busy), 16'h0001);
        i_mem_ctrl_model.send(1'b1, 1'b0, 1'b0, 2'h0, 13'h0010);
        check("cmd_refused", 16'(cmd_refused), 16'h0001);
        @(negedge clk);
        check("acc_valid", 16'(acc_valid), 16'h0000);
        check("cmd_refused", 16'(cmd_refused), 16'h0000);
        wait_idle();
        t_burst(1'b0, 10'h2F9, 3, 1'b1, 3);
        $display("test busy done");
    endtask

    task automatic t_reject();
        logic [12:0] bad [4] = '{13'h0038, 13'h001A, 13'h00B2, 13'h002D};
        for (int i = 0; i < 4; i++)
        begin
            i_mem_ctrl_model.send(1'b0, 1'b0, 1'b1, 2'h0, bad[i]);
            check("mode_reject", 16'(mode_reject), 16'h0001);
            check_settings(3'h3, 1'b1, 3'h3);
            wait_idle();
        end
        for (int b = 1; b < 4; b++)
        begin
            i_mem_ctrl_model.send(1'b0, 1'b0, 1'b1, 2'(b), 13'h0022);
            check("mode_reject", 16'(mode_reject), 16'h0000);
            check("mode_busy", 16'(mode_busy), 16'h0000);
            check_settings(3'h3, 1'b1, 3'h3);
        end
        // A legal load given while a burst runs is refused as a whole.
        i_mem_ctrl_model.send(1'b1, 1'b0, 1'b0, 2'h0, 13'h0100);
        i_mem_ctrl_model.send(1'b0, 1'b0, 1'b1, 2'h0, 13'h0022);
        check("mode_reject", 16'(mode_reject), 16'h0001);
        check_settings(3'h3, 1'b1, 3'h3);
        $display("test reject done");
    endtask

    initial
    begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_modes();
        t_busy();
        t_reject();
        end_sim();
    end
endmodule

// >>> dv/mem_ctrl_model.sv
`timescale 1ns/1ns
module mem_ctrl_model
(
    input  wire logic                             clk,
    output logic                                  cmd_read,
    output logic                                  cmd_write,
    output logic                                  cmd_mode_load,
    output logic                                  bank_select_low,
    output logic                                  bank_select_high,
    output logic [ddr_burst_pkg::ADDR_W-1:0]      cmd_addr
);
    initial
    begin
        cmd_read         = 1'b0;
        cmd_write        = 1'b0;
        cmd_mode_load    = 1'b0;
        bank_select_low  = 1'b0;
        bank_select_high = 1'b0;
        cmd_addr         = '0;
    end

    // Drives one command across a single rising edge, then releases the lines.
    task automatic send(input logic rd, input logic wr, input logic ml, input logic [1:0] bs,
                        input logic [ddr_burst_pkg::ADDR_W-1:0] addr);
        @(negedge clk);
        cmd_read         = rd;
        cmd_write        = wr;
        cmd_mode_load    = ml;
        bank_select_low  = bs[0];
        bank_select_high = bs[1];
        cmd_addr         = addr;
        @(negedge clk);
        cmd_read         = 1'b0;
        cmd_write        = 1'b0;
        cmd_mode_load    = 1'b0;
        // Released lines carry no meaning, so they show the inverse of the last value.
        bank_select_low  = ~bs[0];
        bank_select_high = ~bs[1];
        cmd_addr         = ~addr;
    endtask

    // Loads the standard register and keeps quiet for the whole load wait.
    task automatic load_mode(input logic [ddr_burst_pkg::ADDR_W-1:0] addr);
        send(1'b0, 1'b0, 1'b1, 2'h0, addr);
        repeat (int'(ddr_burst_pkg::MODE_LOAD_WAIT_CYC)) @(negedge clk);
    endtask
endmodule
